// ### tas_monitor.sv
// Alarm, status and command logic of a two-channel temperature monitor with SMBus slave.
// Assumes the analog front end presents settled readings on meas; pins are asynchronous.
`timescale 1ns/1ps

// Notes on behaviour
// - After each conversion compare channels to high and low limits; trip sets flag and alert.
// - Power-on loads high limits with 7f and low limits with c9.
// - Send byte with command 0f is a conversion trigger, not a register write.
// - Free-running: one-shot starts conversion at once; ignored while one is running.
// - Software standby: one-shot runs one conversion, then stays in standby.
// - Hardware standby blocks one-shot conversions.
// - Status is read-only; a read clears limit flags unless the fault persists.
// - Status: bit7 busy, 6..5 local hi/lo, 4..3 remote hi/lo, 2 open, 1..0 zero.
// - Open-diode flag, once set, clears only at power-on reset.
// - Every fault raises the alert; busy never does.
// - Alert is active low open-drain, only pulls low when asserted.
// - Alert latched; status read keeps it; alert-response read clears unless fault persists.
// - Answer read at address 0c while alerted with own address and a one.
// - Power-up: alert clear, rate 02, command pointer 00.
// - At conversion start check diode; fault stores 127, alerts, sets bit4 (and bit2 if open).
// - Only write byte, read byte, send byte and receive byte transfers.
// - Receive byte returns register chosen by the last command byte.
// - Each byte is eight bits, MSB first, then one acknowledge bit.
// - While sending, stop driving if data reads low while released high.
// - Codes 00..08 read, 09..0e write, 0f one-shot.
// - Config bit7 masks alert, bit6 software standby; both zero at power-on.
// - Readings and limits are 8-bit two's complement, 1 degree per count.
// - Hardware standby during conversion aborts it; results stay unchanged.
module tas_monitor #(
    parameter int CONV_CYCLES = tas_pkg::CONV_CYCLES,
    parameter int RATE0_CYCLES = tas_pkg::RATE0_CYCLES
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic scl_pin,
    input wire logic serial_data_pin_in,
    output logic serial_data_pin_out,
    output logic serial_data_pin_oe,
    output tas_pkg::tas_od_t alert_n,
    input wire logic hw_standby_n,
    input wire logic [6:0] dev_addr,
    input wire tas_pkg::tas_meas_t meas
);

    typedef enum logic [2:0] {S_IDLE, S_ADDR, S_AACK, S_RX, S_RACK, S_TX, S_TACK} tas_bus_t;

    // Pin synchronisers; stage one feeds only stage two
    logic scl_s1_ff, scl_s2_ff, scl_d_ff;
    logic sda_s1_ff, sda_s2_ff, sda_d_ff;
    logic hw_standby_n_s1_ff, hw_standby_n_s2_ff;
    logic [6:0] addr_s1_ff, addr_s2_ff;

    always_ff @(posedge core_clk) begin
        scl_s1_ff <= scl_pin;
        scl_s2_ff <= scl_s1_ff;
        scl_d_ff <= scl_s2_ff;
        sda_s1_ff <= serial_data_pin_in;
        sda_s2_ff <= sda_s1_ff;
        sda_d_ff <= sda_s2_ff;
        hw_standby_n_s1_ff <= hw_standby_n;
        hw_standby_n_s2_ff <= hw_standby_n_s1_ff;
        addr_s1_ff <= dev_addr;
        addr_s2_ff <= addr_s1_ff;
    end

    wire scl_rise = scl_s2_ff & ~scl_d_ff;
    wire scl_fall = ~scl_s2_ff & scl_d_ff;
    wire start_c = scl_s2_ff & scl_d_ff & sda_d_ff & ~sda_s2_ff;
    wire stop_c = scl_s2_ff & scl_d_ff & ~sda_d_ff & sda_s2_ff;
    wire hw_hw_standby_n = ~hw_standby_n_s2_ff;

    // Bus engine state
    tas_bus_t st_ff;
    logic [3:0] bitc_ff;
    logic [7:0] shift_ff, txbyte_ff, ptr_ff;
    logic rw_ff, ara_ff, wr_ours_ff, oe_ff;
    logic [1:0] nbytes_ff;

    // Register state
    logic [7:0] cfg_ff, rate_ff, local_ff, remote_ff;
    logic [7:0] lim_ff [4];
    logic [3:0] trip_ff, cond_ff;
    logic open_ff, alert_ff, busy_ff, flt_open_ff, flt_short_ff;
    logic [31:0] conv_cnt_ff, rate_cnt_ff;

    // Decode of the bus events
    wire alert_act = alert_ff & ~cfg_ff[tas_pkg::CFG_MASK_BIT];
    wire byte_in = (bitc_ff == 4'h8) & scl_fall;
    wire addr_hit = shift_ff[7:1] == addr_s2_ff;
    wire ara_hit = (shift_ff[7:1] == tas_pkg::ALERT_RESP_ADDR) & shift_ff[0] & alert_act;
    wire rx_done = (st_ff == S_RX) & byte_in;
    wire cmd_load = rx_done & (nbytes_ff == 2'h0);
    wire data_wr = rx_done & (nbytes_ff == 2'h1);
    wire read_done = (st_ff == S_TACK) & scl_rise;
    wire stat_rd = read_done & ~ara_ff & (ptr_ff == tas_pkg::CMD_RD_STATUS);
    wire ara_rd = read_done & ara_ff;
    wire tx_lost = (st_ff == S_TX) & scl_rise & txbyte_ff[7] & ~sda_s2_ff;
    wire oneshot = stop_c & wr_ours_ff & (nbytes_ff == 2'h1) &
                   (ptr_ff == tas_pkg::CMD_ONE_SHOT);
    wire [7:0] status_byte = {busy_ff, trip_ff[0], trip_ff[1], trip_ff[2], trip_ff[3],
                              open_ff, 2'b00};

    // Transmit byte select
    logic [7:0] tx_sel;
    always_comb begin
        case (ptr_ff)
            tas_pkg::CMD_RD_LOCAL: tx_sel = local_ff;
            tas_pkg::CMD_RD_REMOTE: tx_sel = remote_ff;
            tas_pkg::CMD_RD_STATUS: tx_sel = status_byte;
            tas_pkg::CMD_RD_CFG: tx_sel = cfg_ff;
            tas_pkg::CMD_RD_RATE: tx_sel = rate_ff;
            8'h05, 8'h06, 8'h07, 8'h08: tx_sel = lim_ff[2'(ptr_ff - tas_pkg::CMD_RD_LIM0)];
            default: tx_sel = 8'h00;
        endcase
        if (ara_ff) begin
            tx_sel = {addr_s2_ff, 1'b1};
        end
    end

    // SMBus slave engine
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            st_ff <= S_IDLE;
            bitc_ff <= 4'h0;
            shift_ff <= 8'h00;
            txbyte_ff <= 8'h00;
            ptr_ff <= tas_pkg::PTR_RST;
            rw_ff <= 1'b0;
            ara_ff <= 1'b0;
            wr_ours_ff <= 1'b0;
            oe_ff <= 1'b0;
            nbytes_ff <= 2'h0;
        end else if (start_c) begin
            st_ff <= S_ADDR;
            bitc_ff <= 4'h0;
            nbytes_ff <= 2'h0;
            wr_ours_ff <= 1'b0;
            ara_ff <= 1'b0;
            oe_ff <= 1'b0;
        end else if (stop_c) begin
            st_ff <= S_IDLE;
            oe_ff <= 1'b0;
        end else begin
            case (st_ff)
                S_ADDR, S_RX: begin
                    if (scl_rise) begin
                        shift_ff <= {shift_ff[6:0], sda_s2_ff};
                        bitc_ff <= bitc_ff + 4'h1;
                    end else if (byte_in && st_ff == S_ADDR) begin
                        st_ff <= (addr_hit | ara_hit) ? S_AACK : S_IDLE;
                        oe_ff <= addr_hit | ara_hit;
                        rw_ff <= shift_ff[0];
                        ara_ff <= ara_hit;
                        wr_ours_ff <= addr_hit & ~shift_ff[0];
                    end else if (byte_in) begin
                        st_ff <= S_RACK;
                        oe_ff <= 1'b1;
                        nbytes_ff <= (nbytes_ff == 2'h3) ? nbytes_ff : nbytes_ff + 2'h1;
                        if (cmd_load) begin
                            ptr_ff <= shift_ff;
                        end
                    end
                end
                S_AACK, S_TACK: begin
                    if (read_done && sda_s2_ff) begin
                        st_ff <= S_IDLE;
                    end else if (scl_fall && (rw_ff || st_ff == S_TACK)) begin
                        st_ff <= S_TX;
                        txbyte_ff <= tx_sel;
                        oe_ff <= ~tx_sel[7];
                        bitc_ff <= 4'h0;
                    end else if (scl_fall) begin
                        st_ff <= S_RX;
                        oe_ff <= 1'b0;
                        bitc_ff <= 4'h0;
                    end
                end
                S_RACK: begin
                    if (scl_fall) begin
                        st_ff <= S_RX;
                        oe_ff <= 1'b0;
                        bitc_ff <= 4'h0;
                    end
                end
                S_TX: begin
                    if (tx_lost) begin
                        st_ff <= S_IDLE;
                        oe_ff <= 1'b0;
                    end else if (scl_rise) begin
                        bitc_ff <= bitc_ff + 4'h1;
                    end else if (byte_in) begin
                        st_ff <= S_TACK;
                        oe_ff <= 1'b0;
                    end else if (scl_fall) begin
                        txbyte_ff <= {txbyte_ff[6:0], 1'b0};
                        oe_ff <= ~txbyte_ff[6];
                    end
                end
                default: st_ff <= S_IDLE;
            endcase
        end
    end

    assign serial_data_pin_out = 1'b0;
    assign serial_data_pin_oe = oe_ff;

    // Config and rate writes; limit codes are written below, other codes are accepted and dropped
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            cfg_ff <= tas_pkg::CFG_RST;
            rate_ff <= tas_pkg::RATE_RST;
        end else if (data_wr && ptr_ff == tas_pkg::CMD_WR_CFG) begin
            cfg_ff <= shift_ff;
        end else if (data_wr && ptr_ff == tas_pkg::CMD_WR_RATE) begin
            rate_ff <= shift_ff;
        end
    end

    // Limits and per-limit comparison
    logic [3:0] new_cond;
    for (genvar i = 0; i < 4; i++) begin : g_lim
        wire [7:0] t = (i < 2) ? meas.local_t : (flt_open_ff | flt_short_ff) ?
                       tas_pkg::TEMP_FAULT : meas.remote_t;
        always_ff @(posedge core_clk) begin
            if (!nrst) begin
                lim_ff[i] <= (i % 2 == 0) ? tas_pkg::HIGH_LIMIT_RST : tas_pkg::LOW_LIMIT_RST;
            end else if (data_wr && ptr_ff == tas_pkg::CMD_WR_LIM0 + 8'(i)) begin
                lim_ff[i] <= shift_ff;
            end
        end
        assign new_cond[i] = (i % 2 == 0) ? ($signed(t) >= $signed(lim_ff[i])) :
                             ($signed(t) <= $signed(lim_ff[i]));
    end

    // Conversion sequencer
    wire [2:0] rate_idx = (rate_ff[7:3] != 5'h00) ? tas_pkg::RATE_IDX_MAX : rate_ff[2:0];
    wire [31:0] period = 32'(RATE0_CYCLES) >> rate_idx;
    wire sw_hw_standby_n = cfg_ff[tas_pkg::CFG_HW_STANDBY_N_BIT];
    wire auto_tick = (rate_cnt_ff == 32'h0) & ~sw_hw_standby_n;
    wire conv_start = ~busy_ff & ~hw_hw_standby_n & (oneshot | auto_tick);
    wire conv_abort = busy_ff & hw_hw_standby_n;
    wire conv_done = busy_ff & ~hw_hw_standby_n & (conv_cnt_ff == 32'h1);
    wire diode_bad = meas.diode_open | meas.diode_short;
    wire start_fault = conv_start & diode_bad;
    wire [3:0] cond_eff = {new_cond[3], new_cond[2] | flt_open_ff | flt_short_ff, new_cond[1:0]};
    wire fault_evt = (conv_done & (|cond_eff)) | start_fault;
    wire fault_now = (|cond_ff) | flt_open_ff | flt_short_ff;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            busy_ff <= 1'b0;
            conv_cnt_ff <= 32'h0;
            rate_cnt_ff <= 32'h0;
            flt_open_ff <= 1'b0;
            flt_short_ff <= 1'b0;
            local_ff <= tas_pkg::TEMP_RST;
            remote_ff <= tas_pkg::TEMP_RST;
            cond_ff <= 4'h0;
        end else begin
            busy_ff <= conv_start | (busy_ff & ~conv_done & ~conv_abort);
            conv_cnt_ff <= conv_start ? 32'(CONV_CYCLES) :
                           busy_ff ? conv_cnt_ff - 32'h1 : conv_cnt_ff;
            rate_cnt_ff <= (conv_start | sw_hw_standby_n | hw_hw_standby_n) ? period - 32'h1 :
                           (rate_cnt_ff == 32'h0) ? rate_cnt_ff : rate_cnt_ff - 32'h1;
            if (conv_start) begin
                flt_open_ff <= meas.diode_open;
                flt_short_ff <= meas.diode_short;
            end
            if (conv_done) begin
                local_ff <= meas.local_t;
                remote_ff <= (flt_open_ff | flt_short_ff) ? tas_pkg::TEMP_FAULT : meas.remote_t;
                cond_ff <= cond_eff;
            end
        end
    end

    // Sticky status flags and alert latch; a set beats a clear
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            trip_ff <= 4'h0;
            open_ff <= 1'b0;
            alert_ff <= 1'b0;
        end else begin
            trip_ff <= ({4{conv_done}} & cond_eff) | {1'b0, start_fault, 2'b00} |
                       (stat_rd ? cond_ff : trip_ff);
            open_ff <= open_ff | (conv_start & meas.diode_open);
            alert_ff <= fault_evt | (ara_rd ? fault_now : alert_ff);
        end
    end

    assign alert_n.level = 1'b0;
    assign alert_n.oe = alert_act;

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence s_busy_start;
        !busy_ff ##1 busy_ff;
    endsequence

    property p_reset_vals;
        $rose(nrst) |-> lim_ff[0] == 8'h7f && lim_ff[1] == 8'hc9 && rate_ff == 8'h02 &&
                        ptr_ff == 8'h00 && !alert_ff;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad power-on values");

    property p_shot_busy_ignored;
        oneshot && busy_ff && !hw_hw_standby_n && conv_cnt_ff > 32'h2 |=>
            conv_cnt_ff == $past(conv_cnt_ff) - 32'h1;
    endproperty
    a_shot_busy_ignored: assert property (p_shot_busy_ignored) else $error("one-shot restarted");

    property p_shot_runs;
        oneshot && !busy_ff && !hw_hw_standby_n |-> s_busy_start;
    endproperty
    a_shot_runs: assert property (p_shot_runs) else $error("one-shot did not start");

    property p_hw_block;
        hw_hw_standby_n && !busy_ff |=> !busy_ff;
    endproperty
    a_hw_block: assert property (p_hw_block) else $error("conversion in hw standby");

    property p_stat_clear;
        stat_rd && !conv_done && !start_fault |=> trip_ff == $past(cond_ff);
    endproperty
    a_stat_clear: assert property (p_stat_clear) else $error("status not cleared");

    property p_open_sticky;
        open_ff |=> open_ff;
    endproperty
    a_open_sticky: assert property (p_open_sticky) else $error("open flag dropped");

    property p_alert_cause;
        $rose(alert_ff) |-> $past(fault_evt);
    endproperty
    a_alert_cause: assert property (p_alert_cause) else $error("alert without fault");

    property p_alert_hold;
        alert_ff && !ara_rd |=> alert_ff;
    endproperty
    a_alert_hold: assert property (p_alert_hold) else $error("alert released early");

    property p_arb;
        tx_lost |=> !serial_data_pin_oe && st_ff == S_IDLE;
    endproperty
    a_arb: assert property (p_arb) else $error("kept driving after lost bit");

    property p_abort;
        conv_abort |=> !busy_ff ##0 $stable(local_ff) && $stable(remote_ff);
    endproperty
    a_abort: assert property (p_abort) else $error("abort changed results");

endmodule : tas_monitor

// ### tas_pkg.sv
// Shared constants and carrier types of the temperature alarm monitor.
// Assumes a 100 MHz core clock; every user includes nothing, names are scoped.
package tas_pkg;

    // Power-on values and the diode-fault reading
    localparam logic [7:0] HIGH_LIMIT_RST = 8'h7f;
    localparam logic [7:0] LOW_LIMIT_RST = 8'hc9;
    localparam logic [7:0] RATE_RST = 8'h02;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] PTR_RST = 8'h00;
    localparam logic [7:0] TEMP_RST = 8'h00;
    localparam logic [7:0] TEMP_FAULT = 8'h7f;

    // Command codes
    localparam logic [7:0] CMD_RD_LOCAL = 8'h00;
    localparam logic [7:0] CMD_RD_REMOTE = 8'h01;
    localparam logic [7:0] CMD_RD_STATUS = 8'h02;
    localparam logic [7:0] CMD_RD_CFG = 8'h03;
    localparam logic [7:0] CMD_RD_RATE = 8'h04;
    localparam logic [7:0] CMD_RD_LIM0 = 8'h05;
    localparam logic [7:0] CMD_WR_CFG = 8'h09;
    localparam logic [7:0] CMD_WR_RATE = 8'h0a;
    localparam logic [7:0] CMD_WR_LIM0 = 8'h0b;
    localparam logic [7:0] CMD_ONE_SHOT = 8'h0f;

    localparam logic [6:0] ALERT_RESP_ADDR = 7'h0c;

    // Status and configuration bit positions
    localparam int ST_BUSY = 7;
    localparam int ST_TRIP0 = 6;
    localparam int ST_OPEN = 2;
    localparam int CFG_MASK_BIT = 7;
    localparam int CFG_HW_STANDBY_N_BIT = 6;

    localparam logic [2:0] RATE_IDX_MAX = 3'h7;

    // Timing
    localparam int CLK_KHZ = 100000;
    localparam int CONV_TIME_MS = 170;
    localparam int CONV_CYCLES = CONV_TIME_MS * CLK_KHZ;
    localparam int RATE0_PERIOD_MS = 16000;
    localparam int RATE0_CYCLES = RATE0_PERIOD_MS * CLK_KHZ;

    // Analog front end result, valid whenever sampled
    typedef struct packed {
        logic [7:0] local_t;
        logic [7:0] remote_t;
        logic diode_open;
        logic diode_short;
    } tas_meas_t;

    // Open-drain pin as output level and enable
    typedef struct packed {
        logic level;
        logic oe;
    } tas_od_t;

endpackage : tas_pkg

// ### tas_host.sv
// SMBus master model facing the temperature monitor.
// Assumes an open-drain data line with pull-up; the clock idles high between frames.
`timescale 1ns/1ps
module tas_host (
    input wire logic core_clk,
    input wire logic sda,
    output logic scl,
    output logic sda_oe
);
    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end

    // Quarter of a 160 ns bus clock period
    task automatic q();
        repeat (4) @(negedge core_clk);
    endtask : q

    // Start or repeated start: data falls while the clock is high
    task automatic start();
        sda_oe = 1'b0;
        q();
        scl = 1'b1;
        q();
        sda_oe = 1'b1;
        q();
        scl = 1'b0;
        q();
    endtask : start

    task automatic stop();
        sda_oe = 1'b1;
        q();
        scl = 1'b1;
        q();
        sda_oe = 1'b0;
        q();
    endtask : stop

    task automatic bit_io(input logic b_out, output logic b_in);
        sda_oe = ~b_out;
        q();
        scl = 1'b1;
        q();
        b_in = sda;
        q();
        scl = 1'b0;
        q();
    endtask : bit_io

    task automatic xfer(input logic [7:0] tx, input logic ack_out, output logic [7:0] rx,
                        output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], b);
            rx[i] = b;
        end
        bit_io(ack_out, b);
        ack = ~b;
    endtask : xfer

    task automatic wr_byte(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
                           output logic ok);
        logic [7:0] r;
        logic k1, k2, k3;
        start();
        xfer({a, 1'b0}, 1'b1, r, k1);
        xfer(c, 1'b1, r, k2);
        xfer(d, 1'b1, r, k3);
        stop();
        ok = k1 & k2 & k3;
    endtask : wr_byte

    task automatic send_byte(input logic [6:0] a, input logic [7:0] c, output logic ok);
        logic [7:0] r;
        logic k1, k2;
        start();
        xfer({a, 1'b0}, 1'b1, r, k1);
        xfer(c, 1'b1, r, k2);
        stop();
        ok = k1 & k2;
    endtask : send_byte

    task automatic rd_byte(input logic [6:0] a, input logic [7:0] c, output logic [7:0] d,
                           output logic ok);
        logic [7:0] r;
        logic k1, k2, k3, k4;
        start();
        xfer({a, 1'b0}, 1'b1, r, k1);
        xfer(c, 1'b1, r, k2);
        start();
        xfer({a, 1'b1}, 1'b1, r, k3);
        xfer(8'hff, 1'b1, d, k4);
        stop();
        ok = k1 & k2 & k3;
    endtask : rd_byte

    task automatic recv_byte(input logic [6:0] a, output logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic k;
        start();
        xfer({a, 1'b1}, 1'b1, r, ok);
        xfer(8'hff, 1'b1, d, k);
        stop();
    endtask : recv_byte
endmodule : tas_host

// ### test_temp_alarm_status_smbus_slave.sv
// Self-checking bench for the temperature alarm monitor.
// Assumes tas_host as bus master; conversions shortened to 2000 cycles.
`timescale 1ns/1ps
module test_temp_alarm_status_smbus_slave;
    localparam int CONV = 2000;
    localparam int WAIT_CONV = CONV + 100;
    localparam logic [6:0] OWN_ADDR = 7'h4c; // Arbitrary strap value
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic hw_standby_n = 1'b1;
    logic scl, m_oe, sda, dut_out, dut_oe;
    tas_pkg::tas_od_t alert_n;
    tas_pkg::tas_meas_t meas;
    int num_errors = 0;
    int checked = 0;

    assign sda = ~(m_oe | (dut_oe & ~dut_out));
    always #5 core_clk = ~core_clk;

    tas_monitor #(.CONV_CYCLES(CONV), .RATE0_CYCLES(16000)) dut (
        .core_clk(core_clk), .nrst(nrst), .scl_pin(scl), .serial_data_pin_in(sda),
        .serial_data_pin_out(dut_out), .serial_data_pin_oe(dut_oe), .alert_n(alert_n),
        .hw_standby_n(hw_standby_n), .dev_addr(OWN_ADDR), .meas(meas)
    );
    tas_host host (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_oe(m_oe));

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t byte %h expected %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chk1

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : cyc

    task automatic rd(input logic [7:0] c, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        host.rd_byte(OWN_ADDR, c, d, ok);
        chk1(ok, 1'b1);
        chk8(d, exp);
    endtask : rd

    task automatic wr(input logic [7:0] c, input logic [7:0] v);
        logic ok;
        host.wr_byte(OWN_ADDR, c, v, ok);
        chk1(ok, 1'b1);
    endtask : wr

    task automatic shot();
        logic ok;
        host.send_byte(OWN_ADDR, tas_pkg::CMD_ONE_SHOT, ok);
        chk1(ok, 1'b1);
    endtask : shot

    task automatic ara(input logic exp_ok);
        logic [7:0] d;
        logic ok;
        host.recv_byte(tas_pkg::ALERT_RESP_ADDR, d, ok);
        chk1(ok, exp_ok);
        if (exp_ok) begin
            chk8(d, {OWN_ADDR, 1'b1});
        end
    endtask : ara

    task automatic t_power_on();
        logic [7:0] d;
        logic ok;
        host.recv_byte(OWN_ADDR, d, ok);
        chk8(d, 8'h00);
        chk1(alert_n.oe, 1'b0);
        chk1(alert_n.level, 1'b0);
        rd(8'h03, 8'h00);
        rd(8'h04, 8'h02);
        for (int i = 5; i <= 8; i++) begin
            rd(i[7:0], i[0] ? 8'h7f : 8'hc9);
        end
        wr(8'h09, 8'h40);
        cyc(WAIT_CONV);
        rd(8'h00, 8'h19);
        rd(8'h02, 8'h00);
    endtask : t_power_on

    task automatic t_one_shot();
        wr(8'h0b, 8'h20);
        meas.local_t = 8'h20;
        shot();
        shot();
        rd(8'h02, 8'h80);
        cyc(WAIT_CONV);
        chk1(alert_n.oe, 1'b1);
        rd(8'h02, 8'h40);
        cyc(WAIT_CONV);
        rd(8'h02, 8'h40);
        chk1(alert_n.oe, 1'b1);
        ara(1'b1);
        chk1(alert_n.oe, 1'b1);
        meas.local_t = 8'h10;
        shot();
        cyc(WAIT_CONV);
        rd(8'h02, 8'h40);
        rd(8'h02, 8'h00);
        chk1(alert_n.oe, 1'b1);
        ara(1'b1);
        chk1(alert_n.oe, 1'b0);
        ara(1'b0);
    endtask : t_one_shot

    task automatic t_mask();
        wr(8'h09, 8'hc0);
        meas.local_t = 8'hc0;
        shot();
        cyc(WAIT_CONV);
        chk1(alert_n.oe, 1'b0);
        rd(8'h02, 8'h20);
        wr(8'h09, 8'h40);
        chk1(alert_n.oe, 1'b1);
        meas.local_t = 8'h10;
        shot();
        cyc(WAIT_CONV);
        rd(8'h02, 8'h20);
        ara(1'b1);
        chk1(alert_n.oe, 1'b0);
    endtask : t_mask

    task automatic t_hw_standby();
        meas.local_t = 8'h11;
        hw_standby_n = 1'b0;
        cyc(10);
        shot();
        rd(8'h02, 8'h00);
        hw_standby_n = 1'b1;
        cyc(10);
        shot();
        cyc(200);
        hw_standby_n = 1'b0;
        cyc(WAIT_CONV);
        hw_standby_n = 1'b1;
        cyc(10);
        rd(8'h00, 8'h10);
        rd(8'h02, 8'h00);
    endtask : t_hw_standby

    task automatic t_diode();
        meas.diode_short = 1'b1;
        shot();
        cyc(WAIT_CONV);
        rd(8'h01, 8'h7f);
        rd(8'h02, 8'h10);
        chk1(alert_n.oe, 1'b1);
        meas.diode_short = 1'b0;
        meas.diode_open = 1'b1;
        shot();
        cyc(WAIT_CONV);
        rd(8'h02, 8'h14);
        meas.diode_open = 1'b0;
        shot();
        cyc(WAIT_CONV);
        rd(8'h02, 8'h14);
        rd(8'h02, 8'h04);
        rd(8'h01, 8'h1e);
    endtask : t_diode

    task automatic t_registers();
        logic [7:0] v [6] = '{8'h40, 8'h05, 8'h50, 8'hd0, 8'h60, 8'he0};
        logic [7:0] d;
        logic ok;
        for (int i = 0; i < 6; i++) begin
            wr(8'h09 + i[7:0], v[i]);
            rd(8'h03 + i[7:0], v[i]);
        end
        wr(8'h02, 8'hff);
        wr(8'h05, 8'h11);
        wr(8'h10, 8'h11);
        rd(8'h05, 8'h50);
        rd(8'h02, 8'h04);
        host.recv_byte(OWN_ADDR, d, ok);
        chk8(d, 8'h04);
    endtask : t_registers

    // Host wins bit 2 of a status read; later bits must come back released
    task automatic t_arbitration();
        logic [7:0] d;
        logic k;
        host.start();
        host.xfer({OWN_ADDR, 1'b1}, 1'b1, d, k);
        chk1(k, 1'b1);
        host.xfer(8'h03, 1'b1, d, k);
        host.stop();
        chk8(d, 8'h03);
        chk1(dut_oe, 1'b0);
        rd(8'h02, 8'h04);
    endtask : t_arbitration

    task automatic results();
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results

    initial begin
        meas = {8'h19, 8'h1e, 1'b0, 1'b0};
        cyc(8);
        nrst = 1'b1;
        cyc(4);
        t_power_on();
        t_one_shot();
        t_mask();
        t_hw_standby();
        t_diode();
        t_registers();
        t_arbitration();
        results();
    end

    initial begin
        cyc(90000);
        num_errors++;
        $display("BAD %0t watchdog expired", $time);
        results();
    end
endmodule : test_temp_alarm_status_smbus_slave
